/* core/trig_seq_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts for
  the two-layer trigger sequencer.
  Assumes a 10 MHz core clock and a 32-bit Avalon-MM slave port.
*/
// Operation
// - immediate arm event passes at once
// - bus arm event waits for GET or TRG
// - timer arm: first pass immediate, then interval
// - entering idle resets the arm timer
// - manual key honoured only in local control
// - link arm event waits for link pulse
// - link input line selectable one of four
// - handler start falling, rising or either edge
// - arm bypass only for link/handler events
// - bypass once skips detector, never always waits
// - source bypass: initiate with output on skips arm
// - link trigger detectors individually enabled
// - source detector bypass once or never; the code's bypass bit, when set, skips it on every pass
// - optional output pulse after each action
// - arm output pulse on enter/exit trigger layer
// - arm count finite or infinite
// - source, delay, measure order each iteration
// - idle does nothing until initiate
// - clears and abort force idle at once
// - halt idles, output stays on; restart events
// - output must be on before initiate unless auto-off
// - auto-off: output on per cycle, off after measure
`ifndef TRIG_SEQ_REGS_SVH
`define TRIG_SEQ_REGS_SVH

// ------------------------------------------------------------------
// register word addresses (byte address = 4 * index)
// ------------------------------------------------------------------
`define TS_REG_CTRL      4'h0
`define TS_REG_ARMCFG    4'h1
`define TS_REG_TRIGCFG   4'h2
`define TS_REG_ARMCNT    4'h3
`define TS_REG_TRIGCNT   4'h4
`define TS_REG_TIMER     4'h5
`define TS_REG_DELAY     4'h6
`define TS_REG_STATUS    4'h7
`define TS_REG_CMD       4'h8

// ------------------------------------------------------------------
// command register bits (write-one pulses)
// ------------------------------------------------------------------
`define TS_CMD_INIT      0
`define TS_CMD_MEAS      1
`define TS_CMD_ABORT     2
`define TS_CMD_HALT      3
`define TS_CMD_BUSTRG    4
`define TS_CMD_OUTON     5
`define TS_CMD_OUTOFF    6
`define TS_CMD_RESEL     7

// ------------------------------------------------------------------
// control / arm / trigger configuration fields
// ------------------------------------------------------------------
`define TS_CTRL_AUTOOFF  0
`define TS_CTRL_REMOTE   1
`define TS_ARM_EVT_LSB   0
`define TS_ARM_BYP_LSB   4
`define TS_ARM_IN_LSB    8
`define TS_ARM_OUT_LSB   12
`define TS_ARM_ENTER     16
`define TS_ARM_EXIT      17
`define TS_ARM_INF       18
`define TS_TRG_LINK      0
`define TS_TRG_SRCBYP    1
`define TS_TRG_INEN_LSB  4
`define TS_TRG_IN_LSB    8
`define TS_TRG_OUT_LSB   12
`define TS_TRG_OUTEN_LSB 16

// ------------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------------
`define TS_ARMCFG_RST    32'h0000_0100
`define TS_TRIGCFG_RST   32'h0000_2010
`define TS_CNT_RST       16'h0001
`define TS_DELAY_RST     32'h0000_2710
`define TS_TIMER_RST     32'h0000_0064
`define TS_MEAS_CYC      8'h10
`define TS_PULSE_CYC     8'h0A

`endif

/* core/trig_seq_pkg.sv */
/*
  Types for the two-layer trigger sequencer.
  Assumes trig_seq_regs.svh supplies the numeric constants.
*/
package trig_seq_pkg;
  typedef enum logic [2:0] {
    ARM_IMMEDIATE, ARM_BUS, ARM_TIMER, ARM_MANUAL,
    ARM_LINK, ARM_START_FALL, ARM_START_RISE, ARM_START_EITHER
  } arm_event_t;
  typedef enum logic [1:0] {
    BYP_NEVER, BYP_ONCE, BYP_SOURCE
  } bypass_t;
  typedef enum {
    ST_IDLE, ST_ARM, ST_SRC_WAIT, ST_SOURCE, ST_DLY_WAIT, ST_DELAY,
    ST_MEAS_WAIT, ST_MEASURE, ST_NEXT
  } seq_state_t;
endpackage

/* core/trig_seq.sv */
/*
  Two-layer trigger sequencer: arm layer with selectable event and
  bypass, trigger layer running source, delay and measure actions with
  link trigger inputs and outputs, counters and auto output-off.
  Assumes a single 10 MHz clock, an Avalon-MM master and link/handler
  inputs already synchronous to core_clk.
*/
`timescale 1ns/10ps
`include "trig_seq_regs.svh"
module trig_seq (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  // avalon-mm slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // trigger link and handler
  input  wire logic [3:0]  linkIn,
  output logic [3:0]       linkOutN,
  input  wire logic        startOfTestLine,
  input  wire logic        trigKey,
  // source control and status
  output logic             sourceOutputOn,
  output logic             measureStrobe,
  output logic             armActive
);
  import trig_seq_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q, armCfg_q, trigCfg_q, timer_q, delay_q;
  logic [15:0] armCnt_q, trigCnt_q;
  logic        ackPend_q;
  logic [7:0]  cmd;
  seq_state_t  state_q;
  logic [15:0] armDone_q, trigDone_q;
  logic [31:0] timerCnt_q, work_q;
  logic        timerFirst_q, bypassUsed_q, outOn_q;
  logic [3:0]  linkDly_q;
  logic        sotDly_q;
  logic [7:0]  pulseCnt_q;
  logic [1:0]  pulseLine_q;

  function automatic logic lineSel(input logic [3:0] v,
                                   input logic [1:0] s);
    lineSel = v[s];
  endfunction

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  // one wait state: reads latch at the take edge so data stands at the
  // acknowledge edge; writes and command strobes land at the acknowledge
  assign cmd = (write && ackPend_q && address == `TS_REG_CMD) ?
               writedata[7:0] : 8'h00;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ackPend_q   <= 1'b0;
      waitrequest <= 1'b1;
    end else if (clkEn) begin
      ackPend_q   <= (read || write) && !ackPend_q;
      waitrequest <= !((read || write) && !ackPend_q);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_q    <= 32'h0000_0000;
      armCfg_q  <= `TS_ARMCFG_RST;
      trigCfg_q <= `TS_TRIGCFG_RST;
      armCnt_q  <= `TS_CNT_RST;
      trigCnt_q <= `TS_CNT_RST;
      timer_q   <= `TS_TIMER_RST;
      delay_q   <= `TS_DELAY_RST;
    end else if (clkEn && write && ackPend_q) begin
      case (address)
        `TS_REG_CTRL:    ctrl_q    <= writedata;
        `TS_REG_ARMCFG:  armCfg_q  <= writedata;
        `TS_REG_TRIGCFG: trigCfg_q <= writedata;
        `TS_REG_ARMCNT:  armCnt_q  <= writedata[15:0];
        `TS_REG_TRIGCNT: trigCnt_q <= writedata[15:0];
        `TS_REG_TIMER:   timer_q   <= writedata;
        `TS_REG_DELAY:   delay_q   <= writedata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      readdata <= 32'h0000_0000;
    end else if (clkEn && read && !ackPend_q) begin
      case (address)
        `TS_REG_CTRL:    readdata <= ctrl_q;
        `TS_REG_ARMCFG:  readdata <= armCfg_q;
        `TS_REG_TRIGCFG: readdata <= trigCfg_q;
        `TS_REG_ARMCNT:  readdata <= {16'h0000, armCnt_q};
        `TS_REG_TRIGCNT: readdata <= {16'h0000, trigCnt_q};
        `TS_REG_TIMER:   readdata <= timer_q;
        `TS_REG_DELAY:   readdata <= delay_q;
        `TS_REG_STATUS:  readdata <= {trigDone_q, armDone_q[11:0],
                                      outOn_q, 2'b00,
                                      (state_q != ST_IDLE)};
        default:         readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  arm_event_t armEvt;
  bypass_t    armByp;
  logic [1:0] armIn, armOut, trgIn, trgOut;
  logic [2:0] trgInEn, trgOutEn;
  logic       linkPulse, sotFall, sotRise, armHit, bypassOk;
  logic       trgLink, srcByp, autoOff, remote;

  assign armEvt   = arm_event_t'(armCfg_q[`TS_ARM_EVT_LSB +: 3]);
  assign armByp   = bypass_t'(armCfg_q[`TS_ARM_BYP_LSB +: 2]);
  assign armIn    = armCfg_q[`TS_ARM_IN_LSB +: 2];
  assign armOut   = armCfg_q[`TS_ARM_OUT_LSB +: 2];
  assign trgIn    = trigCfg_q[`TS_TRG_IN_LSB +: 2];
  assign trgOut   = trigCfg_q[`TS_TRG_OUT_LSB +: 2];
  assign trgInEn  = trigCfg_q[`TS_TRG_INEN_LSB +: 3];
  assign trgOutEn = trigCfg_q[`TS_TRG_OUTEN_LSB +: 3];
  assign trgLink  = trigCfg_q[`TS_TRG_LINK];
  assign srcByp   = trigCfg_q[`TS_TRG_SRCBYP];
  assign autoOff  = ctrl_q[`TS_CTRL_AUTOOFF];
  assign remote   = ctrl_q[`TS_CTRL_REMOTE];

  // edge detect; link pulse is a falling edge
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      linkDly_q <= 4'hF;
      sotDly_q  <= 1'b1;
    end else if (clkEn) begin
      linkDly_q <= linkIn;
      sotDly_q  <= startOfTestLine;
    end
  end
  logic [3:0] linkFall;
  assign linkFall = linkDly_q & ~linkIn;
  assign sotFall  = sotDly_q & ~startOfTestLine;
  assign sotRise  = ~sotDly_q & startOfTestLine;

  // bypass only for link and handler start events
  assign bypassOk = (armEvt == ARM_LINK) || (armEvt == ARM_START_FALL) ||
                    (armEvt == ARM_START_RISE) ||
                    (armEvt == ARM_START_EITHER);

  always_comb begin
    linkPulse = 1'b0;
    armHit    = 1'b0;
    case (armEvt)
      ARM_IMMEDIATE:    armHit = 1'b1;
      ARM_BUS:          armHit = cmd[`TS_CMD_BUSTRG];
      ARM_TIMER:        armHit = timerFirst_q || timerCnt_q >= timer_q;
      ARM_MANUAL:       armHit = trigKey && !remote;
      ARM_LINK:         armHit = lineSel(linkFall, armIn);
      ARM_START_FALL:   armHit = sotFall;
      ARM_START_RISE:   armHit = sotRise;
      ARM_START_EITHER: armHit = sotFall || sotRise;
      default:          armHit = 1'b0;
    endcase
    if (state_q != ST_ARM) begin
      linkPulse = lineSel(linkFall, trgIn);
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic initReq, stopReq, toIdle;
  assign initReq = cmd[`TS_CMD_INIT] || cmd[`TS_CMD_MEAS];
  // abort and halt force idle
  assign stopReq = cmd[`TS_CMD_ABORT] || cmd[`TS_CMD_HALT];

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q      <= ST_IDLE;
      armDone_q    <= 16'h0000;
      trigDone_q   <= 16'h0000;
      work_q       <= 32'h0000_0000;
      bypassUsed_q <= 1'b0;
    end else if (clkEn) begin
      if (stopReq) begin
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (initReq) begin
              armDone_q    <= 16'h0000;
              trigDone_q   <= 16'h0000;
              bypassUsed_q <= 1'b0;
              if (bypassOk && armByp == BYP_SOURCE && outOn_q) begin
                state_q <= ST_SRC_WAIT;
              end else begin
                state_q <= ST_ARM;
              end
            end
          end
          ST_ARM: begin
            if (armHit || (bypassOk && armByp == BYP_ONCE &&
                           !bypassUsed_q)) begin
              bypassUsed_q <= 1'b1;
              state_q      <= ST_SRC_WAIT;
            end
          end
          ST_SRC_WAIT: begin
            if (!trgLink || !trgInEn[0] || srcByp || linkPulse) begin
              state_q <= ST_SOURCE;
            end
          end
          ST_SOURCE: begin
            work_q  <= delay_q;
            state_q <= ST_DLY_WAIT;
          end
          ST_DLY_WAIT: begin
            if (!trgLink || !trgInEn[1] || linkPulse) begin
              state_q <= ST_DELAY;
            end
          end
          ST_DELAY: begin
            if (work_q == 32'h0000_0000) begin
              state_q <= ST_MEAS_WAIT;
            end else begin
              work_q <= work_q - 32'h0000_0001;
            end
          end
          ST_MEAS_WAIT: begin
            if (!trgLink || !trgInEn[2] || linkPulse) begin
              work_q  <= {24'h000000, `TS_MEAS_CYC};
              state_q <= ST_MEASURE;
            end
          end
          ST_MEASURE: begin
            if (work_q == 32'h0000_0000) begin
              trigDone_q <= trigDone_q + 16'h0001;
              state_q    <= ST_NEXT;
            end else begin
              work_q <= work_q - 32'h0000_0001;
            end
          end
          ST_NEXT: begin
            if (trigDone_q < trigCnt_q) begin
              state_q <= ST_SRC_WAIT;
            end else if (armCfg_q[`TS_ARM_INF] ||
                         armDone_q + 16'h0001 < armCnt_q) begin
              armDone_q  <= armDone_q + 16'h0001;
              trigDone_q <= 16'h0000;
              state_q    <= ST_ARM;
            end else begin
              state_q <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // arm interval timer
  // ----------------------------------------------------------------
  // arm interval timer, reset in idle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      timerCnt_q   <= 32'h0000_0000;
      timerFirst_q <= 1'b1;
    end else if (clkEn) begin
      if (state_q == ST_IDLE) begin
        timerCnt_q   <= 32'h0000_0000;
        timerFirst_q <= 1'b1;
      end else if (state_q == ST_ARM && armEvt == ARM_TIMER && armHit) begin
        timerCnt_q   <= 32'h0000_0000;
        timerFirst_q <= 1'b0;
      end else if (timerCnt_q != 32'hFFFF_FFFF) begin
        timerCnt_q <= timerCnt_q + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // source output
  // ----------------------------------------------------------------
  // source output control
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      outOn_q <= 1'b0;
    end else if (clkEn) begin
      if (cmd[`TS_CMD_OUTOFF]) begin
        outOn_q <= 1'b0;
      end else if (cmd[`TS_CMD_OUTON] ||
                   (cmd[`TS_CMD_MEAS] && !autoOff)) begin
        outOn_q <= 1'b1;
      end else if (autoOff && state_q == ST_SOURCE) begin
        outOn_q <= 1'b1;
      end else if (autoOff && state_q == ST_MEASURE &&
                   work_q == 32'h0000_0000) begin
        outOn_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // output triggers
  // ----------------------------------------------------------------
  // output trigger pulses, active low on the link
  logic fireTrg, fireArm;
  assign fireTrg = (state_q == ST_SOURCE && trgOutEn[0]) ||
                   (state_q == ST_DELAY && work_q == 32'h0000_0000 &&
                    trgOutEn[1]) ||
                   (state_q == ST_MEASURE && work_q == 32'h0000_0000 &&
                    trgOutEn[2]);
  assign fireArm = (state_q == ST_ARM && armCfg_q[`TS_ARM_ENTER] &&
                    (armHit || (bypassOk && armByp == BYP_ONCE &&
                                !bypassUsed_q))) ||
                   (state_q == ST_NEXT && trigDone_q >= trigCnt_q &&
                    armCfg_q[`TS_ARM_EXIT]);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pulseCnt_q  <= 8'h00;
      pulseLine_q <= 2'b00;
      linkOutN    <= 4'hF;
    end else if (clkEn) begin
      if (fireTrg || fireArm) begin
        pulseCnt_q  <= `TS_PULSE_CYC;
        pulseLine_q <= fireTrg ? trgOut : armOut;
        linkOutN    <= ~(4'h1 << (fireTrg ? trgOut : armOut));
      end else if (pulseCnt_q != 8'h00) begin
        pulseCnt_q <= pulseCnt_q - 8'h01;
        if (pulseCnt_q == 8'h01) begin
          linkOutN <= 4'hF;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sourceOutputOn <= 1'b0;
      measureStrobe  <= 1'b0;
      armActive      <= 1'b0;
    end else if (clkEn) begin
      sourceOutputOn <= outOn_q;
      measureStrobe  <= state_q == ST_MEASURE && work_q == 32'h0000_0000;
      armActive      <= state_q != ST_IDLE;
    end
  end
endmodule

/* sim/trig_seq_chk.sv */
/*
  Port-level checker for trig_seq, bound to every instance.
  Assumes one Avalon-MM master; checks pause while clkEn is low.
*/
`timescale 1ns/10ps
`include "trig_seq_regs.svh"
module trig_seq_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        clkEn,
  // register bus
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // sequencer outputs
  input wire logic [3:0]  linkOutN,
  input wire logic        sourceOutputOn,
  input wire logic        measureStrobe,
  input wire logic        armActive
);
  logic autoOff_q;
  logic cmdAck;

  assign cmdAck = write && !waitrequest && address == `TS_REG_CMD;

  // shadow of the auto output-off bit, taken at the write's ack edge
  always_ff @(posedge core_clk) begin
    if (!resetn) autoOff_q <= 1'b0;
    else if (write && !waitrequest && address == `TS_REG_CTRL)
      autoOff_q <= writedata[`TS_CTRL_AUTOOFF];
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn || !clkEn);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_ack_next: assert property (
    clkEn && (read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not acknowledged one cycle later");
  a_ack_single: assert property (!waitrequest |=> waitrequest)
    else $error("acknowledge held longer than one cycle");
  a_ack_cause: assert property (!waitrequest |-> $past(read || write))
    else $error("acknowledge without a request");
  a_unmapped_zero: assert property (
    read && !waitrequest && address > `TS_REG_CMD |-> readdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  a_strobe_single: assert property (measureStrobe |=> !measureStrobe)
    else $error("measure strobe longer than one cycle");
  a_strobe_armed: assert property (
    measureStrobe |-> armActive || $past(armActive))
    else $error("measurement while idle");
  a_out_width: assert property (
    $fell(&linkOutN) |-> ##9 !(&linkOutN) ##1 (&linkOutN))
    else $error("output trigger pulse not ten cycles");
  a_auto_off: assert property (
    autoOff_q && measureStrobe |-> ##[0:20] !sourceOutputOn)
    else $error("output not switched off after measurement");
  a_abort_idle: assert property (
    cmdAck && writedata[`TS_CMD_ABORT] |-> ##[1:3] !armActive)
    else $error("abort did not force idle");

  c_strobe: cover property (measureStrobe);
  c_out_pulse: cover property ($fell(&linkOutN));
  c_abort: cover property (cmdAck && writedata[`TS_CMD_ABORT]);
endmodule

bind trig_seq trig_seq_chk i_trig_seq_chk (
  .core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
  .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .linkOutN(linkOutN),
  .sourceOutputOn(sourceOutputOn), .measureStrobe(measureStrobe),
  .armActive(armActive));

/* sim/link_partner.sv */
/*
  Model of the far side: another instrument on the link lines and a
  component handler on the start-of-test line.
  Assumes the bench calls its tasks from the core_clk domain.
*/
`timescale 1ns/10ps
module link_partner #(
  parameter int PULSE_CYC = 3
) (
  // clock
  input wire logic  core_clk,
  // lines towards the sequencer
  output logic [3:0] linkIn,
  output logic       startOfTestLine
);
  // lines are pulled up, so idle is high
  initial begin
    linkIn = 4'hF;
    startOfTestLine = 1'b1;
  end

  task automatic linkPulse(input int line);
    @(posedge core_clk);
    linkIn[line] <= 1'b0;
    repeat (PULSE_CYC) @(posedge core_clk);
    linkIn[line] <= 1'b1;
  endtask

  task automatic sotLevel(input logic v);
    @(posedge core_clk);
    startOfTestLine <= v;
  endtask
endmodule

/* sim/trig_seq_tb_top.sv */
/*
  Self-checking bench for trig_seq: register bus tasks and one task per
  scenario. Assumes link_partner drives the link and handler lines.
*/
`timescale 1ns/10ps
`include "trig_seq_regs.svh"
`define CHK(nm, e, g) checks++; \
  if ((g) !== (e)) begin fails++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end
module trig_seq_tb_top;
  logic        core_clk, resetn, clkEn, read, write, waitrequest;
  logic        trigKey, startOfTestLine, sourceOutputOn;
  logic        measureStrobe, armActive, sawOn;
  logic [3:0]  address, linkIn, linkOutN, sawOut;
  logic [31:0] writedata, readdata, rdQ;
  int          fails, checks, c;

  trig_seq i_trig_seq (.core_clk(core_clk), .resetn(resetn),
    .clkEn(clkEn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .linkIn(linkIn), .linkOutN(linkOutN),
    .startOfTestLine(startOfTestLine), .trigKey(trigKey),
    .sourceOutputOn(sourceOutputOn), .measureStrobe(measureStrobe),
    .armActive(armActive));
  link_partner i_link_partner (.core_clk(core_clk), .linkIn(linkIn),
    .startOfTestLine(startOfTestLine));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    address <= a; write <= wr; read <= ~wr; writedata <= d;
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    rdQ = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // counts measure strobes over n settled cycles
  task automatic cnt(input int n);
    c = 0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (measureStrobe !== 1'b0) c++;
      if (sourceOutputOn === 1'b1) sawOn = 1'b1;
      sawOut |= ~linkOutN;
    end
  endtask
  task automatic key;
    @(posedge core_clk) trigKey <= 1'b1;
    @(posedge core_clk) trigKey <= 1'b0;
  endtask
  task automatic fin(input string nm);
    wr(`TS_REG_CMD, 32'h4);
    $display("test %s done", nm);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    rd(`TS_REG_ARMCFG); `CHK("armcfg", `TS_ARMCFG_RST, rdQ)
    rd(`TS_REG_TRIGCFG); `CHK("trigcfg", `TS_TRIGCFG_RST, rdQ)
    rd(`TS_REG_ARMCNT); `CHK("armcnt", `TS_CNT_RST, rdQ[15:0])
    rd(4'hC); `CHK("unmapped", 32'h0, rdQ)
    wr(`TS_REG_DELAY, 32'h2);
    $display("test reset done");
  endtask
  task automatic t_immediate;
    wr(`TS_REG_CTRL, 32'h1); wr(`TS_REG_ARMCFG, 32'h0);
    wr(`TS_REG_TRIGCNT, 32'h2); sawOn = 1'b0; wr(`TS_REG_CMD, 32'h1);
    cnt(38); `CHK("first strobe", 1, c)
    cnt(150); `CHK("second strobe", 1, c)
    `CHK("output on", 1'b1, sawOn)
    rd(`TS_REG_STATUS); `CHK("run and out", 2'b00, {rdQ[3], rdQ[0]})
    wr(`TS_REG_TRIGCNT, 32'h1); fin("immediate");
  endtask
  task automatic t_bus;
    wr(`TS_REG_CTRL, 32'h0); wr(`TS_REG_CMD, 32'h20);
    wr(`TS_REG_ARMCFG, 32'h1); wr(`TS_REG_CMD, 32'h1);
    cnt(40); `CHK("no bus trig", 0, c)
    wr(`TS_REG_CMD, 32'h10); cnt(100); `CHK("bus trig", 1, c)
    `CHK("output stays", 1'b1, sourceOutputOn)
    fin("bus");
  endtask
  task automatic t_bypass;
    logic [31:0] cfg[3] = '{32'h11, 32'h214, 32'h224};
    int want[3] = '{0, 1, 1};
    for (int i = 0; i < 3; i++) begin
      wr(`TS_REG_ARMCFG, cfg[i]); wr(`TS_REG_CMD, 32'h1);
      cnt(80); `CHK("bypass", want[i], c)
      wr(`TS_REG_CMD, 32'h4);
    end
    fin("bypass");
  endtask
  task automatic t_link;
    wr(`TS_REG_TRIGCFG, 32'h0004_3000); wr(`TS_REG_ARMCFG, 32'h1_0204);
    sawOut = 4'h0; wr(`TS_REG_CMD, 32'h1);
    i_link_partner.linkPulse(1); cnt(40); `CHK("other line", 0, c)
    i_link_partner.linkPulse(2); cnt(100); `CHK("link arm", 1, c)
    `CHK("out lines", 4'h9, sawOut)
    wr(`TS_REG_TRIGCFG, 32'h53); wr(`TS_REG_ARMCFG, 32'h0);
    wr(`TS_REG_CMD, 32'h1);
    cnt(60); `CHK("meas held", 0, c)
    i_link_partner.linkPulse(0); cnt(60); `CHK("meas go", 1, c)
    wr(`TS_REG_TRIGCFG, `TS_TRIGCFG_RST); fin("link");
  endtask
  task automatic t_manual;
    wr(`TS_REG_CTRL, 32'h2); wr(`TS_REG_ARMCFG, 32'h3);
    wr(`TS_REG_CMD, 32'h1);
    key; cnt(40); `CHK("remote key", 0, c)
    wr(`TS_REG_CTRL, 32'h0); key; cnt(60); `CHK("local key", 1, c)
    fin("manual");
  endtask
  task automatic t_handler;
    wr(`TS_REG_ARMCFG, 32'h6); i_link_partner.sotLevel(1'b0);
    wr(`TS_REG_CMD, 32'h1);
    cnt(40); `CHK("rise idle", 0, c)
    i_link_partner.sotLevel(1'b1); cnt(60); `CHK("rise", 1, c)
    wr(`TS_REG_ARMCFG, 32'h5); wr(`TS_REG_CMD, 32'h1);
    cnt(40); `CHK("fall idle", 0, c)
    i_link_partner.sotLevel(1'b0); cnt(60); `CHK("fall", 1, c)
    wr(`TS_REG_ARMCFG, 32'h7); wr(`TS_REG_CMD, 32'h1);
    i_link_partner.sotLevel(1'b1); cnt(60); `CHK("either", 1, c)
    fin("handler");
  endtask
  task automatic t_timer;
    wr(`TS_REG_TIMER, 32'd100); wr(`TS_REG_ARMCNT, 32'h2);
    wr(`TS_REG_ARMCFG, 32'h2); wr(`TS_REG_CMD, 32'h1);
    cnt(50); `CHK("timer first", 1, c)
    cnt(40); `CHK("timer wait", 0, c)
    cnt(60); `CHK("timer next", 1, c)
    wr(`TS_REG_CMD, 32'h1); cnt(35); `CHK("timer rearm", 1, c)
    wr(`TS_REG_ARMCNT, 32'h1); fin("timer");
  endtask
  task automatic t_abort;
    wr(`TS_REG_ARMCFG, 32'h1); wr(`TS_REG_CMD, 32'h1); cnt(5);
    rd(`TS_REG_STATUS); `CHK("running", 1'b1, rdQ[0])
    wr(`TS_REG_CMD, 32'h4);
    rd(`TS_REG_STATUS); `CHK("aborted", 1'b0, rdQ[0])
    cnt(40); `CHK("no strobe", 0, c)
    wr(`TS_REG_CMD, 32'h1); wr(`TS_REG_CMD, 32'h8);
    rd(`TS_REG_STATUS); `CHK("halt", 2'b10, {rdQ[3], rdQ[0]})
    fin("abort");
  endtask
  // freeze by clkEn, then a reset in mid-run
  task automatic t_freeze;
    wr(`TS_REG_ARMCFG, 32'h0); wr(`TS_REG_CMD, 32'h1);
    clkEn <= 1'b0; cnt(40); `CHK("frozen", 0, c)
    clkEn <= 1'b1; cnt(40); `CHK("thawed", 1, c)
    wr(`TS_REG_CMD, 32'h1); repeat (3) @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    cnt(1); `CHK("reset idle", 1'b0, armActive)
    rd(`TS_REG_DELAY); `CHK("delay rst", `TS_DELAY_RST, rdQ)
    $display("test freeze done");
  endtask

  task automatic summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // a full run needs about 1750 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    $display("ERROR watchdog expected finish seen hang");
    summarize;
  end

  initial begin
    resetn = 1'b0; clkEn = 1'b1; address = 4'h0; read = 1'b0;
    write = 1'b0; writedata = 32'h0; trigKey = 1'b0;
    fails = 0; checks = 0; sawOn = 1'b0; sawOut = 4'h0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset; t_immediate; t_bus; t_bypass; t_link;
    t_manual; t_handler; t_timer; t_abort; t_freeze;
    summarize;
  end
endmodule
